//--- hw/wdt_pkg.sv
package wdt_pkg;

  // Bus data width and the word that software sees
  localparam int          DATA_W          = 32;
  localparam int          ADDR_W          = 18;

  // Register indices; the byte address is four times the index
  localparam logic [15:0] IDX_SERVICE     = 16'hffff;
  localparam logic [15:0] IDX_CONFIG      = 16'h0000;
  localparam logic [15:0] IDX_STATUS      = 16'h0001;
  localparam logic [17:0] ADDR_SERVICE    = {IDX_SERVICE, 2'b00};
  localparam logic [17:0] ADDR_CONFIG     = {IDX_CONFIG, 2'b00};
  localparam logic [17:0] ADDR_STATUS     = {IDX_STATUS, 2'b00};

  // Config register fields
  localparam int          CFG_SHORT_BIT   = 0;
  localparam int          CFG_DISABLE_BIT = 1;
  localparam logic [1:0]  CFG_RESET       = 2'h0;

  // Status register fields
  localparam int          ST_CAUSE_BIT    = 0;
  localparam int          ST_RESET_BIT    = 1;
  localparam int          ST_ENABLE_BIT   = 2;
  localparam int          ST_CNT_LSB      = 8;

  // Timebase geometry
  localparam int          PRESC_W         = 12;
  localparam int          WCNT_W          = 6;
  localparam int          CHAIN_W         = PRESC_W + WCNT_W;
  localparam int          SVC_CLR_LSB     = 4;

  // Timeout lengths in crystal clock cycles
  localparam int          LONG_CYCLES     = (1 << 18) - (1 << 4);
  localparam int          SHORT_CYCLES    = (1 << 13) - (1 << 4);

  // Reset pin low time in crystal clock cycles
  localparam int          RST_PULSE_CYC   = 32;

  // Crystal clock period in ns that the chain runs on
  localparam int          CLK_PERIOD_NS   = 25;

  // AXI responses
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

endpackage : wdt_pkg

//--- hw/wdt_sync3.sv
`timescale 1ns/10ps
module wdt_sync3 #(
  parameter int W = 1
) (
  input  wire logic         mclk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } wdt_sync_t;

  wdt_sync_t st_ff;
  wdt_sync_t nxt_st;

  initial begin
    if (W < 1) $error("wdt_sync3 width must be at least one");
  end

  // Output follows only once stages two and three agree, so a single glitch is dropped
  always_comb begin
    nxt_st    = st_ff;
    nxt_st.s1 = din;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    nxt_st.q  = (~(st_ff.s2 ^ st_ff.s3) & st_ff.s3) | ((st_ff.s2 ^ st_ff.s3) & st_ff.q);
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign dout = st_ff.q;

endmodule : wdt_sync3

//--- hw/wdt_rst_stretch.sv
`timescale 1ns/10ps
module wdt_rst_stretch #(
  parameter int LEN = 32
) (
  input  wire logic mclk,
  input  wire logic arst_n,
  input  wire logic trigger,
  output logic      busy
);

  localparam int CW = (LEN > 1) ? $clog2(LEN) : 1;

  typedef struct packed {
    logic          busy;
    logic [CW-1:0] left;
  } wdt_stretch_t;

  wdt_stretch_t st_ff;
  wdt_stretch_t nxt_st;

  initial begin
    if (LEN < 1) $error("wdt_rst_stretch length must be at least one");
  end

  // A trigger during a pulse is absorbed; the pulse is never shortened or restarted
  always_comb begin
    nxt_st = st_ff;
    if (st_ff.busy) begin
      if (st_ff.left == '0) begin
        nxt_st.busy = 1'b0;
      end else begin
        nxt_st.left = st_ff.left - 1'b1;
      end
    end else if (trigger) begin
      nxt_st.busy = 1'b1;
      nxt_st.left = CW'(LEN - 1);
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign busy = st_ff.busy;

endmodule : wdt_rst_stretch

//--- hw/wdt_top.sv
`timescale 1ns/10ps
// How it works
// [R1] A 12-bit prescaler ripples into a 6-bit watchdog counter, both free running.
// [R2] The whole chain runs on mclk, which is the crystal clock, nothing else.
// [R3] Chain reaching the selected limit overflows and fires the system reset.
// [R4] Short-timeout option set selects the long period of 2^18 minus 2^4 cycles.
// [R5] Any write to the service word clears counter and prescaler bits 11 to 4.
// [R6] Reading the service word returns the reset vector low byte.
// [R7] Watchdog reset drives the reset pin low 32 cycles, sets cause flag.
// [R8] Stop instruction clears the whole prescaler.
// [R9] Internal reset clears prescaler and watchdog counter.
// [R10] Reset vector fetch clears the prescaler.
// [R11] Disable option suppresses every watchdog reset.
// [R12] No interrupt request is ever raised; reset is the only action.
// [R13] Monitor mode with high voltage on interrupt or reset pin disables watchdog.
// [R14] Break state with high voltage on the reset pin disables watchdog.
// [R15] Wait mode does not stop counting.
// [R16] Stop mode freezes the chain and holds the prescaler cleared.
// [R17] Software should clear the stop-enable option to keep the watchdog clock.
// [R18] Software should service soon after reset and around stop mode.
// [R19] Software should service from the main program, except in wait mode.
// [R20] Removing high voltage in monitor mode re-enables, subject to the disable option.
// [R21] A service write is one decoded bus write giving a one-cycle clear pulse.
module wdt_top #(
  parameter int LONG_CYCLES  = wdt_pkg::LONG_CYCLES,
  parameter int SHORT_CYCLES = wdt_pkg::SHORT_CYCLES
) (
  input  wire logic                       mclk,
  input  wire logic                       arst_n,
  input  wire logic [wdt_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [wdt_pkg::DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [wdt_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [wdt_pkg::DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  input  wire logic [7:0]                 reset_vector_low,
  input  wire logic                       stop_exec,
  input  wire logic                       stop_mode,
  input  wire logic                       wait_mode,
  input  wire logic                       internal_reset,
  input  wire logic                       reset_vector_fetch,
  input  wire logic                       monitor_mode,
  input  wire logic                       break_state,
  input  wire logic                       hv_irq_pin,
  input  wire logic                       hv_rst_pin,
  output logic                            rst_pin_o,
  output logic                            rst_pin_oe,
  output logic                            system_reset_n
);

  localparam int AW = wdt_pkg::ADDR_W;
  localparam int CW = wdt_pkg::CHAIN_W;
  localparam int PW = wdt_pkg::PRESC_W;
  localparam int NW = wdt_pkg::WCNT_W;

  localparam logic [CW-1:0] LONG_LAST  = CW'(LONG_CYCLES - 1);
  localparam logic [CW-1:0] SHORT_LAST = CW'(SHORT_CYCLES - 1);

  typedef struct packed {
    logic                       aw_pend;
    logic [AW-1:0]              aw_addr;
    logic                       w_pend;
    logic [wdt_pkg::DATA_W-1:0] w_data;
    logic [3:0]                 w_strb;
    logic                       bvalid;
    logic [1:0]                 bresp;
    logic                       rvalid;
    logic [wdt_pkg::DATA_W-1:0] rdata;
    logic [1:0]                 rresp;
    logic [PW-1:0]              presc;
    logic [NW-1:0]              wcnt;
    logic                       short_timeout_option;
    logic                       watchdog_disable_option;
    logic                       cause;
  } wdt_state_t;

  wdt_state_t st_ff;
  wdt_state_t nxt_st;

  logic [1:0]    hv_sync;
  logic          hv_irq;
  logic          hv_rst;
  logic          rst_busy;
  logic          wd_en;
  logic [CW-1:0] chain;
  logic [CW-1:0] chain_inc;
  logic          ovf;
  logic          trigger;
  logic          chain_clr;
  logic          svc;
  logic          wr_go;
  logic          rd_go;

  initial begin
    if (AW < 18) $error("wdt_top address width too small for the service word");
    if (LONG_CYCLES < 2 || LONG_CYCLES > (1 << CW)) $error("wdt_top long period out of range");
    if (SHORT_CYCLES < 2 || SHORT_CYCLES > LONG_CYCLES) $error("wdt_top short period out of range");
  end

  // High-voltage detects come from pins and cross into mclk
  wdt_sync3 #(
    .W    (2)
  ) u_hv_sync (
    .mclk   (mclk),
    .arst_n (arst_n),
    .din    ({hv_rst_pin, hv_irq_pin}),
    .dout   (hv_sync)
  );

  assign hv_irq = hv_sync[0];
  assign hv_rst = hv_sync[1];

  // Stretch a single overflow into a fixed-length reset pin pulse
  wdt_rst_stretch #(
    .LEN    (wdt_pkg::RST_PULSE_CYC)
  ) u_stretch (
    .mclk    (mclk),
    .arst_n  (arst_n),
    .trigger (trigger),
    .busy    (rst_busy)
  );

  // Enable is purely combinational so dropping a high voltage re-enables at once
  assign wd_en = !st_ff.watchdog_disable_option                  // R11 R20
               && !(monitor_mode && (hv_irq || hv_rst))          // R13 R20
               && !(break_state && hv_rst);                      // R14

  // Prescaler forms the low bits of one long chain
  assign chain     = {st_ff.wcnt, st_ff.presc};                  // R1
  assign chain_inc = chain + 1'b1;
  assign ovf       = !stop_mode
                   && (chain == (st_ff.short_timeout_option ? LONG_LAST : SHORT_LAST)); // R3 R4
  assign trigger   = ovf && wd_en && !rst_busy;                  // R11 R12
  assign chain_clr = internal_reset || trigger || rst_busy;      // R9

  // Bus handshakes; address and data are taken independently
  assign s_axi_awready = !st_ff.aw_pend && !st_ff.bvalid;
  assign s_axi_wready  = !st_ff.w_pend && !st_ff.bvalid;
  assign s_axi_arready = !st_ff.rvalid;
  assign wr_go         = st_ff.aw_pend && st_ff.w_pend;
  assign rd_go         = s_axi_arvalid && s_axi_arready;
  assign svc           = wr_go && (st_ff.aw_addr[17:0] == wdt_pkg::ADDR_SERVICE); // R21

  // Bus slave, option bits, cause flag and the timebase chain
  always_comb begin
    nxt_st = st_ff;

    if (s_axi_awvalid && s_axi_awready) begin
      nxt_st.aw_pend = 1'b1;
      nxt_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_st.w_pend = 1'b1;
      nxt_st.w_data = s_axi_wdata;
      nxt_st.w_strb = s_axi_wstrb;
    end
    if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end

    // Write takes effect the cycle after both halves are held
    if (wr_go) begin
      nxt_st.aw_pend = 1'b0;
      nxt_st.w_pend  = 1'b0;
      nxt_st.bvalid  = 1'b1;
      nxt_st.bresp   = wdt_pkg::RESP_OKAY;
      case (st_ff.aw_addr[17:0])
        wdt_pkg::ADDR_SERVICE: begin
          nxt_st.bresp = wdt_pkg::RESP_OKAY;                     // R5
        end
        wdt_pkg::ADDR_CONFIG: begin
          if (st_ff.w_strb[0]) begin
            nxt_st.short_timeout_option    = st_ff.w_data[wdt_pkg::CFG_SHORT_BIT];
            nxt_st.watchdog_disable_option = st_ff.w_data[wdt_pkg::CFG_DISABLE_BIT];
          end
        end
        wdt_pkg::ADDR_STATUS: begin
          if (st_ff.w_strb[0] && st_ff.w_data[wdt_pkg::ST_CAUSE_BIT]) begin
            nxt_st.cause = 1'b0;
          end
        end
        default: begin
          nxt_st.bresp = wdt_pkg::RESP_SLVERR;
        end
      endcase
      // The address port is exactly as wide as the decode, so no upper
      // bits can alias a register; every word outside the map takes
      // the default branch above and answers SLVERR
    end

    // Set wins over a software clear in the same cycle
    if (trigger) begin
      nxt_st.cause = 1'b1;                                       // R7
    end

    if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end
    if (rd_go) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp  = wdt_pkg::RESP_OKAY;
      nxt_st.rdata  = '0;
      case (s_axi_araddr[17:0])
        wdt_pkg::ADDR_SERVICE: begin
          nxt_st.rdata[7:0] = reset_vector_low;                  // R6
        end
        wdt_pkg::ADDR_CONFIG: begin
          nxt_st.rdata[wdt_pkg::CFG_SHORT_BIT]   = st_ff.short_timeout_option;
          nxt_st.rdata[wdt_pkg::CFG_DISABLE_BIT] = st_ff.watchdog_disable_option;
        end
        wdt_pkg::ADDR_STATUS: begin
          nxt_st.rdata[wdt_pkg::ST_CAUSE_BIT]  = st_ff.cause;
          nxt_st.rdata[wdt_pkg::ST_RESET_BIT]  = rst_busy;
          nxt_st.rdata[wdt_pkg::ST_ENABLE_BIT] = wd_en;
          nxt_st.rdata[wdt_pkg::ST_CNT_LSB +: NW] = st_ff.wcnt;
        end
        default: begin
          nxt_st.rresp = wdt_pkg::RESP_SLVERR;
        end
      endcase
      // A hole reads as zero, so a stray read of one can never pass
      // for the reset vector byte
    end

    // Chain counts in wait mode as in run mode; only stop mode halts it
    if (!stop_mode) begin
      {nxt_st.wcnt, nxt_st.presc} = ovf ? '0 : chain_inc;        // R15 R3
    end
    // Low four prescaler bits survive a service, so the period is slightly short
    if (svc) begin
      nxt_st.wcnt = '0;                                          // R5
      nxt_st.presc[PW-1:wdt_pkg::SVC_CLR_LSB] = '0;              // R5
    end
    if (stop_exec || stop_mode || reset_vector_fetch) begin
      nxt_st.presc = '0;                                         // R8 R10 R16
    end
    if (chain_clr) begin
      nxt_st.presc = '0;                                         // R9
      nxt_st.wcnt  = '0;                                         // R9
    end
  end

  // Option bits and cause flag are not cleared by the watchdog's own reset
  always_ff @(posedge mclk or negedge arst_n) begin // R2
    if (!arst_n) begin
      st_ff                         <= '0;
      st_ff.short_timeout_option    <= wdt_pkg::CFG_RESET[wdt_pkg::CFG_SHORT_BIT];
      st_ff.watchdog_disable_option <= wdt_pkg::CFG_RESET[wdt_pkg::CFG_DISABLE_BIT];
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Open-drain reset pin: only ever pulled low
  assign rst_pin_o      = 1'b0;
  assign rst_pin_oe     = rst_busy;                              // R7
  assign system_reset_n = !rst_busy;                             // R12
  assign s_axi_bvalid   = st_ff.bvalid;
  assign s_axi_bresp    = st_ff.bresp;
  assign s_axi_rvalid   = st_ff.rvalid;
  assign s_axi_rdata    = st_ff.rdata;
  assign s_axi_rresp    = st_ff.rresp;

  // Helper: length of the current reset pin pulse
  logic [7:0] oe_len_ff;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      oe_len_ff <= 8'h00;
    end else begin
      oe_len_ff <= rst_pin_oe ? oe_len_ff + 8'h01 : 8'h00;
    end
  end

  // Checks sample on mclk and stay quiet while arst_n is low
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  sequence s_svc_read;
    rd_go && (s_axi_araddr == AW'(wdt_pkg::ADDR_SERVICE));
  endsequence

  sequence s_vec_answer;
    s_axi_rvalid && (s_axi_rdata[7:0] == $past(reset_vector_low)) && (s_axi_rdata[31:8] == '0);
  endsequence

  sequence s_pulse_start;
    trigger ##1 rst_pin_oe;
  endsequence

  AST_RST_WIDTH: assert property ($fell(rst_pin_oe) |-> oe_len_ff == 8'(wdt_pkg::RST_PULSE_CYC)) // R7
    else $error("reset pin pulse not 32 cycles");
  AST_CAUSE_SET: assert property (s_pulse_start |-> st_ff.cause && !system_reset_n) // R7
    else $error("watchdog reset without cause flag");
  AST_VEC_READ: assert property (s_svc_read |=> s_vec_answer) // R6
    else $error("service read did not return vector low byte");
  AST_SVC_CLEAR: assert property (svc |=> (st_ff.wcnt == '0) && (st_ff.presc < 12'h010)) // R5
    else $error("service write did not clear the chain");
  AST_STOP_CLR: assert property (stop_exec |=> st_ff.presc == '0) // R8
    else $error("stop instruction left prescaler running");
  AST_INT_RST: assert property (internal_reset |=> chain == '0) // R9
    else $error("internal reset did not clear the chain");
  AST_VEC_FETCH: assert property (reset_vector_fetch |=> st_ff.presc == '0) // R10
    else $error("vector fetch did not clear prescaler");
  AST_DISABLE: assert property (st_ff.watchdog_disable_option |-> !trigger) // R11
    else $error("reset fired while disabled");
  AST_MON_HV: assert property (monitor_mode && (hv_irq || hv_rst) |-> !wd_en) // R13
    else $error("watchdog enabled in monitor mode with high voltage");
  AST_BRK_HV: assert property (break_state && hv_rst |-> !wd_en) // R14
    else $error("watchdog enabled in break state with high voltage");
  AST_MON_REEN: assert property ($fell(hv_irq) && monitor_mode && !hv_rst && !break_state
                                 && !st_ff.watchdog_disable_option |-> wd_en) // R20
    else $error("watchdog not re-enabled after high voltage removed");
  AST_WAIT_RUN: assert property (wait_mode && !stop_mode && !ovf && !chain_clr && !svc
                                 && !stop_exec && !reset_vector_fetch
                                 |=> chain == $past(chain) + 1'b1) // R15
    else $error("chain stalled in wait mode");
  AST_STOP_FREEZE: assert property (stop_mode && !chain_clr && !svc
                                    |=> (st_ff.wcnt == $past(st_ff.wcnt)) && (st_ff.presc == '0)) // R16
    else $error("chain moved in stop mode");
  AST_PERIOD: assert property (trigger |-> chain == (st_ff.short_timeout_option ? LONG_LAST
                                                     : SHORT_LAST)) // R3 R4
    else $error("overflow at wrong chain value");
  AST_STOP_NO_FIRE: assert property (stop_mode |-> !trigger) // R16
    else $error("watchdog fired while its clock was stopped");
  AST_PULSE_CLR: assert property (rst_busy |=> chain == '0) // R9
    else $error("chain ran during the reset pulse");

endmodule : wdt_top

//--- dv/watchdog_reset_timer_tb_top.sv
`timescale 1ns/10ps
module watchdog_reset_timer_tb_top;
  // Shortened periods keep the run brief; expectations derive from these
  localparam int LIM_L = 200;
  localparam int LIM_S = 40;

  logic        mclk, arst_n;
  logic [17:0] awaddr, araddr;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, r;
  logic [7:0]  rvl;
  logic        stop_exec, stop_mode, wait_mode, int_rst, vfetch;
  logic        mon, brk, hv_irq, hv_rst, rst_o, rst_oe, sys_rst_n;
  logic [4:0]  cs;
  int          n_errors, compares, seed, t, w, base, n_rst, i, k;

  wdt_top #(.LONG_CYCLES(LIM_L), .SHORT_CYCLES(LIM_S)) uut (
    .mclk               (mclk),
    .arst_n             (arst_n),
    .s_axi_awaddr       (awaddr),
    .s_axi_awvalid      (awvalid),
    .s_axi_awready      (awready),
    .s_axi_wdata        (wdata),
    .s_axi_wstrb        (wstrb),
    .s_axi_wvalid       (wvalid),
    .s_axi_wready       (wready),
    .s_axi_bresp        (bresp),
    .s_axi_bvalid       (bvalid),
    .s_axi_bready       (bready),
    .s_axi_araddr       (araddr),
    .s_axi_arvalid      (arvalid),
    .s_axi_arready      (arready),
    .s_axi_rdata        (rdata),
    .s_axi_rresp        (rresp),
    .s_axi_rvalid       (rvalid),
    .s_axi_rready       (rready),
    .reset_vector_low   (rvl),
    .stop_exec          (stop_exec),
    .stop_mode          (stop_mode),
    .wait_mode          (wait_mode),
    .internal_reset     (int_rst),
    .reset_vector_fetch (vfetch),
    .monitor_mode       (mon),
    .break_state        (brk),
    .hv_irq_pin         (hv_irq),
    .hv_rst_pin         (hv_rst),
    .rst_pin_o          (rst_o),
    .rst_pin_oe         (rst_oe),
    .system_reset_n     (sys_rst_n)
  );

  // Crystal clock, 25 ns period
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // Cycles spent with the reset pin pulled; a delta of zero means no reset
  always @(posedge mclk) begin
    if (rst_oe === 1'b1) n_rst <= n_rst + 1;
  end

  task chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task chk_resp(input logic [1:0] g, input logic [1:0] e);
    chk({30'h0, g}, {30'h0, e});
  endtask : chk_resp

  task chk_cnt(input int g, input int e);
    chk(32'(g), 32'(e));
  endtask : chk_cnt

  task complete_run;
    $display("Comparisons %0d, mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : complete_run

  task hang;
    n_errors++;
    $display("Error at %0t: wait bound used up, got %h expected %h", $time, 1'b0, 1'b1);
    complete_run();
  endtask : hang

  // Both write halves offered together; extra edge keeps bready from toggling twice
  task axw(input logic [17:0] a, input logic [31:0] dd, input logic [3:0] s,
           output logic [1:0] rs);
    int j;
    awaddr <= a;
    wdata <= dd;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (j = 0; j < 40; j++) begin
      @(posedge mclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        rs = bresp;
        bready <= 1'b0;
        break;
      end
    end
    if (j == 40) hang();
    @(posedge mclk);
  endtask : axw

  task axr(input logic [17:0] a, output logic [31:0] dd, output logic [1:0] rs);
    int j;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (j = 0; j < 40; j++) begin
      @(posedge mclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        dd = rdata;
        rs = rresp;
        rready <= 1'b0;
        break;
      end
    end
    if (j == 40) hang();
    @(posedge mclk);
  endtask : axr

  // One-cycle internal reset puts the chain back at zero
  task restart;
    int_rst <= 1'b1;
    @(posedge mclk);
    int_rst <= 1'b0;
    @(posedge mclk);
    base = n_rst;
  endtask : restart

  // Waits up to n edges for the reset pin; returns start edge and pulse width
  task watch(input int n, output int tt, output int ww);
    int j;
    tt = -1;
    ww = 0;
    for (j = 0; j < n && tt < 0; j++) begin
      @(posedge mclk);
      if (rst_oe === 1'b1) tt = j;
    end
    if (tt >= 0) begin
      chk({30'h0, rst_o, sys_rst_n}, 32'h0);
      ww = 1;
      for (j = 0; j < 100; j++) begin
        @(posedge mclk);
        if (rst_oe !== 1'b1) break;
        ww++;
      end
    end
  endtask : watch

  function automatic int in_win(input int g, input int lim);
    return (g >= lim - 4 && g <= lim + 2) ? 1 : 0;
  endfunction : in_win

  initial begin
    {awaddr, araddr, awvalid, wvalid, bready, arvalid, rready, wdata, wstrb} = '0;
    {stop_exec, stop_mode, wait_mode, int_rst, vfetch, mon, brk, hv_irq, hv_rst} = '0;
    n_errors = 0;
    compares = 0;
    n_rst = 0;
    seed = 32'h166b9bed;
    rvl = 8'($random(seed));
    arst_n = 1'b0;
    repeat (10) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    // Register map, reset values, unmapped place, strobe gating
    axr(wdt_pkg::ADDR_CONFIG, d, r);
    chk(d, 32'h0);
    chk_resp(r, wdt_pkg::RESP_OKAY);
    axr(wdt_pkg::ADDR_STATUS, d, r);
    chk(d, 32'h4);
    axr(wdt_pkg::ADDR_SERVICE, d, r);
    chk(d, {24'h0, rvl});
    axr(18'h00008, d, r);
    chk(d, 32'h0);
    chk_resp(r, wdt_pkg::RESP_SLVERR);
    axw(18'h00010, 32'h1, 4'hf, r);
    chk_resp(r, wdt_pkg::RESP_SLVERR);
    axw(wdt_pkg::ADDR_CONFIG, 32'h3, 4'h0, r);
    chk_resp(r, wdt_pkg::RESP_OKAY);
    axr(wdt_pkg::ADDR_CONFIG, d, r);
    chk(d, 32'h0);
    axw(wdt_pkg::ADDR_CONFIG, 32'h2, 4'hf, r);
    axr(wdt_pkg::ADDR_STATUS, d, r);
    chk(d, 32'h0);
    axw(wdt_pkg::ADDR_CONFIG, 32'h0, 4'hf, r);
    $display("Test registers done");
    // Short period, counting on through wait mode, pulse width and cause flag
    wait_mode <= 1'b1;
    restart();
    watch(LIM_S + 20, t, w);
    chk_cnt(in_win(t, LIM_S), 1);
    chk_cnt(w, wdt_pkg::RST_PULSE_CYC);
    axr(wdt_pkg::ADDR_STATUS, d, r);
    chk(d & 32'h1, 32'h1);
    axw(wdt_pkg::ADDR_STATUS, 32'h1, 4'hf, r);
    axr(wdt_pkg::ADDR_STATUS, d, r);
    chk(d, 32'h4);
    wait_mode <= 1'b0;
    $display("Test short timeout done");
    // Option bit set selects the long period
    axw(wdt_pkg::ADDR_CONFIG, 32'h1, 4'hf, r);
    restart();
    watch(LIM_L + 20, t, w);
    chk_cnt(in_win(t, LIM_L), 1);
    axw(wdt_pkg::ADDR_CONFIG, 32'h0, 4'hf, r);
    $display("Test long timeout done");
    // Random data and random gaps on service writes hold reset off
    restart();
    for (k = 0; k < 12; k++) begin
      repeat (2 + ({$random(seed)} % 8)) @(posedge mclk);
      axw(wdt_pkg::ADDR_SERVICE, $random(seed), 4'($random(seed)), r);
    end
    chk_cnt(n_rst - base, 0);
    $display("Test service done");
    // Stop instruction, vector fetch and stop mode each keep the chain low
    for (k = 0; k < 3; k++) begin
      restart();
      for (i = 0; i < 3 * LIM_S; i++) begin
        @(posedge mclk);
        stop_exec <= (k == 0) && (i % 15 == 0);
        vfetch <= (k == 1) && (i % 15 == 0);
        stop_mode <= (k == 2);
      end
      @(posedge mclk);
      {stop_exec, vfetch, stop_mode} <= 3'h0;
      chk_cnt(n_rst - base, 0);
    end
    $display("Test stop and fetch done");
    // Disable option suppresses every watchdog reset
    axw(wdt_pkg::ADDR_CONFIG, 32'h2, 4'hf, r);
    restart();
    repeat (3 * LIM_S) @(posedge mclk);
    chk_cnt(n_rst - base, 0);
    axw(wdt_pkg::ADDR_CONFIG, 32'h0, 4'hf, r);
    $display("Test disable done");
    // Monitor and break with high voltage; last case must still fire
    for (k = 0; k < 4; k++) begin
      case (k)
        0: cs = 5'b10100;
        1: cs = 5'b10010;
        2: cs = 5'b01010;
        default: cs = 5'b01101;
      endcase
      {mon, brk, hv_irq, hv_rst} <= cs[4:1];
      repeat (6) @(posedge mclk);
      restart();
      watch(2 * LIM_S, t, w);
      chk_cnt(t >= 0, int'(cs[0]));
      if (!cs[0]) begin
        {hv_irq, hv_rst} <= 2'h0;
        watch(LIM_S + 20, t, w);
        chk_cnt(t >= 0, 1);
      end
      {mon, brk, hv_irq, hv_rst} <= 4'h0;
      @(posedge mclk);
    end
    $display("Test high voltage done");
    complete_run();
  end

  // Overall bound on the run
  initial begin
    repeat (100000) @(posedge mclk);
    hang();
  end

endmodule : watchdog_reset_timer_tb_top
